// ---- hw/sec_status_pkg.sv ----
// Constants for the secondary status register bank.
// Assumes a 32-bit classic Wishbone register port in front of it.
package sec_status_pkg;
    // Register map
    localparam logic [7:0] STATUS_OFFS = 8'h44; // Command half low, status half high
    localparam logic [7:0] CTRL_OFFS = 8'h4c; // Control word of this bank
    // Field positions in the status dword
    localparam int INTP_BIT = 19;
    localparam int CAPL_BIT = 20;
    localparam int M66_BIT = 21;
    localparam int FB2B_BIT = 23;
    localparam int MDPE_BIT = 24;
    localparam int DSEL_LO = 25;
    localparam int STA_BIT = 27;
    localparam int RTA_BIT = 28;
    localparam int RMA_BIT = 29;
    localparam int SSE_BIT = 30;
    localparam int DPE_BIT = 31;
    // Control word fields
    localparam int PERR_EN_BIT = 0;
    localparam int REVERSE_BIT = 1;
    localparam int CONV_BIT = 2;
    // Reset and fixed values
    localparam logic [1:0] DSEL_FWD = 2'h1; // Medium decode
    localparam logic [1:0] DSEL_REV = 2'h0;
    localparam logic CAPL_VAL = 1'b1;
    localparam logic [2:0] CTRL_RESET = 3'h4; // Forward, conventional bus, enable off
endpackage : sec_status_pkg

// ---- hw/sec_status_bank.sv ----
// Secondary-side status half-word with sticky, write-one-clear error flags.
// Assumes event inputs are one-cycle pulses from logic on CLK; the
// parity error pin arrives from outside and is synchronised here.
`timescale 1ns/1ns
module sec_status_bank (
    input wire logic CLK, // 50 MHz bridge clock
    input wire logic RST, // Asynchronous reset, active high
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [7:0] WB_ADR_I, // Byte address
    input wire logic [3:0] WB_SEL_I, // Byte lane selects
    input wire logic [31:0] WB_DAT_I, // Write data
    output logic [31:0] WB_DAT_O, // Read data
    output logic WB_ACK_O, // Acknowledge
    input wire logic INTX_PENDING, // Secondary INTx request pending, level
    input wire logic PARITY_ERROR_PIN_N, // Secondary parity error pin, async
    input wire logic SENDING_WR_DATA, // Bridge drives write data on the bus
    input wire logic SPLIT_WR_RESP, // Bridge receives a split response for a write
    input wire logic SPLIT_MSG_WR_PERR, // Split completion message: write parity error
    input wire logic RX_POISONED_CPL, // Reverse: poisoned completion received
    input wire logic TX_POISONED_WR, // Reverse: bridge poisons a write request
    input wire logic RX_POISONED_TLP, // Reverse: any poisoned packet received
    input wire logic TX_CPL_CA, // Reverse: bridge completes with completer abort
    input wire logic RX_CPL_CA, // Reverse: completion with completer abort
    input wire logic RX_CPL_UR, // Reverse: completion with unsupported request
    input wire logic TX_ERR_MSG, // Reverse: fatal or non-fatal message sent
    input wire logic TGT_ABORT_SIGNALED, // Forward: bridge signals target abort
    input wire logic TGT_ABORT_DETECTED, // Forward: bridge detects target abort
    input wire logic MST_ABORT_DETECTED, // Forward: own transaction master aborted
    input wire logic SYSTEM_ERROR_OUT_N, // Forward: system error output, same clock
    input wire logic BUS_PERR_DETECTED, // Forward: address or data parity error
    output logic REVERSE_MODE, // Bank is in reverse bridge mode
    output logic PERR_RESP_EN // Secondary parity error response enable
);

    logic [2:0] ctrl_r; // Parity enable, reverse mode, conventional bus
    logic [15:0] cmd_r; // Lower half-word kept as plain storage
    logic mdpe_r; // Master data parity error flag
    logic sta_r; // Signaled target abort flag
    logic rta_r; // Received target abort flag
    logic rma_r; // Received master abort flag
    logic sse_r; // Signaled system error flag
    logic dpe_r; // Detected parity error flag
    logic intp_r; // Pending interrupt, registered
    logic perr_s1_r; // Parity pin, first stage
    logic perr_s2_r; // Parity pin, second stage
    logic serr_prev_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic req;
    logic wr_stat;
    logic [31:0] clr;
    logic rev;
    logic fwd;
    logic perr_seen;
    logic serr_fall;
    logic perr_en; // Parity response enable bit
    logic conv; // Secondary bus in conventional mode
    logic mdpe_rev_set; // Reverse-mode parity conditions
    logic mdpe_fwd_set; // Forward-mode parity conditions
    logic mdpe_set; // Gated set of the master data parity flag
    logic sta_set;
    logic rta_set;
    logic rma_set;
    logic sse_set;
    logic dpe_set;

    // Register-side handshake: one access per request, ack drops after one cycle
    assign req = WB_CYC_I && WB_STB_I && !ack_r;
    assign wr_stat = req && WB_WE_I && (WB_ADR_I == sec_status_pkg::STATUS_OFFS);
    assign rev = ctrl_r[sec_status_pkg::REVERSE_BIT];
    assign fwd = !rev;

    // Byte-lane mask of ones written; a set event still wins over the clear
    function automatic logic [31:0] lane_ones(input logic [3:0] sel, input logic [31:0] d);
        lane_ones = d & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_ones

    // Next state for a sticky flag: set beats clear
    function automatic logic sticky(input logic cur, input logic set, input logic clr_b);
        sticky = set | (cur & ~clr_b);
    endfunction : sticky

    assign clr = wr_stat ? lane_ones(WB_SEL_I, WB_DAT_I) : 32'h0;

    // Parity pin comes from the bus, two flops before use
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            perr_s1_r <= 1'b1;
            perr_s2_r <= 1'b1;
        end else begin
            perr_s1_r <= PARITY_ERROR_PIN_N;
            perr_s2_r <= perr_s1_r;
        end
    end

    // Falling edge of the system error output; it is produced on this clock
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            serr_prev_r <= 1'b1;
        end else begin
            serr_prev_r <= SYSTEM_ERROR_OUT_N;
        end
    end

    assign perr_seen = !perr_s2_r && (SENDING_WR_DATA || SPLIT_WR_RESP);
    assign serr_fall = serr_prev_r && !SYSTEM_ERROR_OUT_N;

    // Pending-interrupt level sampled; same-clock source, one cycle of delay
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            intp_r <= 1'b0;
        end else begin
            intp_r <= INTX_PENDING;
        end
    end

    // Address decodes, shared by the write and read paths
    function automatic logic is_status(input logic [7:0] a);
        is_status = (a == sec_status_pkg::STATUS_OFFS);
    endfunction : is_status

    // Control word lives at its own offset, outside the status dword
    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a == sec_status_pkg::CTRL_OFFS);
    endfunction : is_ctrl

    // Picks the reverse or forward event; only one source feeds a flag at a time,
    // so an event of the idle mode can never leave a stale flag behind
    function automatic logic by_mode(input logic r, input logic rev_ev, input logic fwd_ev);
        by_mode = r ? rev_ev : fwd_ev;
    endfunction : by_mode

    // Mode and enable bits pulled out once so every flag reads the same copy
    assign perr_en = ctrl_r[sec_status_pkg::PERR_EN_BIT];
    assign conv = ctrl_r[sec_status_pkg::CONV_BIT];

    // Control word; only lane 0 carries the three live bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_r <= sec_status_pkg::CTRL_RESET;
        end else if (req && WB_WE_I && is_ctrl(WB_ADR_I) && WB_SEL_I[0]) begin
            ctrl_r <= WB_DAT_I[2:0];
        end
    end

    // Command half kept as plain storage; lanes 2 and 3 go to the status clears
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmd_r <= 16'h0;
        end else if (req && WB_WE_I && is_status(WB_ADR_I)) begin
            if (WB_SEL_I[0]) begin
                cmd_r[7:0] <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                cmd_r[15:8] <= WB_DAT_I[15:8];
            end
        end
    end

    // Reverse-side conditions: poisoned completion in, or a write poisoned out
    assign mdpe_rev_set = RX_POISONED_CPL || TX_POISONED_WR;
    // Forward-side conditions: pin during write traffic, or a split message
    assign mdpe_fwd_set = perr_seen || SPLIT_MSG_WR_PERR;
    // Only this flag is gated; with the enable off the error is simply not logged
    assign mdpe_set = perr_en && by_mode(rev, mdpe_rev_set, mdpe_fwd_set);

    // Master data parity flag; a clear landing with a new error loses to it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mdpe_r <= 1'b0;
        end else begin
            mdpe_r <= sticky(mdpe_r, mdpe_set, clr[sec_status_pkg::MDPE_BIT]);
        end
    end

    // Set events per flag, each chosen by the live mode bit
    assign sta_set = by_mode(rev, TX_CPL_CA, TGT_ABORT_SIGNALED);
    assign rta_set = by_mode(rev, RX_CPL_CA, TGT_ABORT_DETECTED);
    assign rma_set = by_mode(rev, RX_CPL_UR, MST_ABORT_DETECTED);
    assign sse_set = by_mode(rev, TX_ERR_MSG, serr_fall);
    // Detected parity ignores the response enable in both modes
    assign dpe_set = by_mode(rev, RX_POISONED_TLP, BUS_PERR_DETECTED);

    // Signaled target abort flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sta_r <= 1'b0;
        end else begin
            sta_r <= sticky(sta_r, sta_set, clr[sec_status_pkg::STA_BIT]);
        end
    end

    // Received target abort flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rta_r <= 1'b0;
        end else begin
            rta_r <= sticky(rta_r, rta_set, clr[sec_status_pkg::RTA_BIT]);
        end
    end

    // Received master abort flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rma_r <= 1'b0;
        end else begin
            rma_r <= sticky(rma_r, rma_set, clr[sec_status_pkg::RMA_BIT]);
        end
    end

    // Signaled system error flag; forward mode counts edges, not the low level,
    // so a long assertion of the output cannot re-set a flag software cleared
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sse_r <= 1'b0;
        end else begin
            sse_r <= sticky(sse_r, sse_set, clr[sec_status_pkg::SSE_BIT]);
        end
    end

    // Detected parity error flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dpe_r <= 1'b0;
        end else begin
            dpe_r <= sticky(dpe_r, dpe_set, clr[sec_status_pkg::DPE_BIT]);
        end
    end

    // Read-only capability bits; they follow the mode live, so a mode change
    // shows on the very next read without any reset
    function automatic logic [31:0] fixed_bits(input logic f, input logic c);
        logic [31:0] w;
        w = 32'h0;
        w[sec_status_pkg::CAPL_BIT] = sec_status_pkg::CAPL_VAL;
        w[sec_status_pkg::M66_BIT] = f;
        w[sec_status_pkg::FB2B_BIT] = f && c;
        w[sec_status_pkg::DSEL_LO +: 2] = f ? sec_status_pkg::DSEL_FWD
                                            : sec_status_pkg::DSEL_REV;
        fixed_bits = w;
    endfunction : fixed_bits

    // Pending level and sticky flags at their places; reserved bits stay zero
    function automatic logic [31:0] flag_bits();
        logic [31:0] w;
        w = 32'h0;
        w[sec_status_pkg::INTP_BIT] = intp_r;
        w[sec_status_pkg::MDPE_BIT] = mdpe_r;
        w[sec_status_pkg::STA_BIT] = sta_r;
        w[sec_status_pkg::RTA_BIT] = rta_r;
        w[sec_status_pkg::RMA_BIT] = rma_r;
        w[sec_status_pkg::SSE_BIT] = sse_r;
        w[sec_status_pkg::DPE_BIT] = dpe_r;
        flag_bits = w;
    endfunction : flag_bits

    // Status dword as read: command half below, status half above
    function automatic logic [31:0] status_word(input logic f, input logic c);
        status_word = {16'h0, cmd_r} | fixed_bits(f, c) | flag_bits();
    endfunction : status_word

    // Ack one cycle after the request; it blocks a second take of the same request
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // Read data latched with the request; unmapped reads return zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dat_r <= 32'h0;
        end else if (req && !WB_WE_I) begin
            if (is_status(WB_ADR_I)) begin
                dat_r <= status_word(fwd, conv);
            end else if (is_ctrl(WB_ADR_I)) begin
                dat_r <= {29'h0, ctrl_r};
            end else begin
                dat_r <= 32'h0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign REVERSE_MODE = ctrl_r[sec_status_pkg::REVERSE_BIT];
    assign PERR_RESP_EN = ctrl_r[sec_status_pkg::PERR_EN_BIT];

endmodule : sec_status_bank

// ---- tb/sec_status_checker.sv ----
// Port assertions for the secondary status bank.
// Assumes binding to sec_status_bank; sees only its ports.
`timescale 1ns/1ns
module sec_status_checker (
    input wire logic CLK, // Clock
    input wire logic RST, // Async reset
    input wire logic WB_CYC_I, // Cycle
    input wire logic WB_STB_I, // Strobe
    input wire logic WB_WE_I, // Write
    input wire logic [7:0] WB_ADR_I, // Address
    input wire logic [31:0] WB_DAT_O, // Read data
    input wire logic WB_ACK_O, // Ack
    input wire logic INTX_PENDING, // Pending level
    input wire logic REVERSE_MODE // Mode
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Decodes of a request being taken, judged one cycle later at the ack
    wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire logic rd_st = req && !WB_WE_I && WB_ADR_I == sec_status_pkg::STATUS_OFFS;
    wire logic rd_un = req && !WB_WE_I && WB_ADR_I != sec_status_pkg::STATUS_OFFS
        && WB_ADR_I != sec_status_pkg::CTRL_OFFS;
    wire logic st_ack = WB_ACK_O;
    ack_answer_a: assert property (req |=> WB_ACK_O) else $error("no ack after request");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    cap_bit_a: assert property ($past(rd_st) && st_ack |-> WB_DAT_O[20])
        else $error("capability bit low");
    mode_bits_a: assert property ($past(rd_st) && st_ack |-> WB_DAT_O[21] == !REVERSE_MODE
        && WB_DAT_O[26:25] == (REVERSE_MODE ? 2'h0 : 2'h1))
        else $error("mode bits wrong");
    fast_b2b_a: assert property ($past(rd_st) && st_ack && REVERSE_MODE |-> !WB_DAT_O[23])
        else $error("fast back-to-back set in reverse");
    rsvd_zero_a: assert property ($past(rd_st) && st_ack |-> !WB_DAT_O[22] && !WB_DAT_O[18])
        else $error("reserved bit set");
    unmapped_a: assert property ($past(rd_un) && st_ack |-> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    intx_bit_a: assert property ($past(rd_st) && st_ack |->
        WB_DAT_O[19] == $past(INTX_PENDING, 2)) else $error("pending bit wrong");
endmodule : sec_status_checker
bind sec_status_bank sec_status_checker i_chk (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .INTX_PENDING(INTX_PENDING), .REVERSE_MODE(REVERSE_MODE));

// ---- tb/sec_agents.sv ----
// Behavioural secondary-side agents that raise error events.
// Assumes the bench asks for one event at a time through GO and PICK.
`timescale 1ns/1ns
module sec_agents (
    input wire logic CLK, // Clock
    input wire logic GO, // Fire request
    input wire logic [3:0] PICK, // Event index
    input wire logic HOLD, // Hold parity pin during write data
    output logic [15:0] EV = 16'h0, // One-cycle events
    output logic PIN_N, // Parity pin, pulled up when released
    output logic WR_DATA // Write data phase
);
    // One clock per event, as the bank expects one-cycle pulses
    always_ff @(posedge CLK) begin
        EV <= GO ? 16'h1 << PICK : 16'h0;
    end
    // Pin and qualifier move together so the pin is seen inside the data phase
    assign PIN_N = !HOLD;
    assign WR_DATA = HOLD;
endmodule : sec_agents

// ---- tb/tb.sv ----
// Self-checking bench for the secondary status bank.
// Assumes package, agents and checker are compiled before it.
`timescale 1ns/1ns
module tb;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [46:0] bus = 47'h0; // cyc, stb, we, adr, sel, dat
    logic [4:0] gp = 5'h0; // go, pick
    logic hold = 1'b0, intx = 1'b0, ack, rev, pen, pin_n, wrd;
    logic [31:0] dout, rdata;
    logic [15:0] ev;
    int mismatches = 0, checked = 0, cycles = 0;
    localparam logic [31:0] FWD = 32'h02b0_0000;
    localparam logic [31:0] REV = 32'h0010_0000;
    localparam logic [7:0] ST = 8'h44;
    localparam logic [7:0] CT = 8'h4c;
    always #10 CLK = ~CLK;
    sec_agents i_agents (.CLK(CLK), .GO(gp[4]), .PICK(gp[3:0]), .HOLD(hold), .EV(ev),
        .PIN_N(pin_n), .WR_DATA(wrd));
    sec_status_bank i_dut (.CLK(CLK), .RST(RST), .WB_CYC_I(bus[46]), .WB_STB_I(bus[45]),
        .WB_WE_I(bus[44]), .WB_ADR_I(bus[43:36]), .WB_SEL_I(bus[35:32]), .WB_DAT_I(bus[31:0]),
        .WB_DAT_O(dout), .WB_ACK_O(ack), .INTX_PENDING(intx), .PARITY_ERROR_PIN_N(pin_n),
        .SENDING_WR_DATA(wrd), .SPLIT_WR_RESP(ev[13]), .SPLIT_MSG_WR_PERR(ev[0]),
        .RX_POISONED_CPL(ev[1]), .TX_POISONED_WR(ev[2]), .RX_POISONED_TLP(ev[3]),
        .TX_CPL_CA(ev[4]), .RX_CPL_CA(ev[5]), .RX_CPL_UR(ev[6]), .TX_ERR_MSG(ev[7]),
        .TGT_ABORT_SIGNALED(ev[8]), .TGT_ABORT_DETECTED(ev[9]), .MST_ABORT_DETECTED(ev[10]),
        .SYSTEM_ERROR_OUT_N(!ev[11]), .BUS_PERR_DETECTED(ev[12]), .REVERSE_MODE(rev),
        .PERR_RESP_EN(pen));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Classic cycle; a silent slave is caught by the bench timeout, not here
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge CLK);
        bus <= {2'b11, w, a, s, d};
        do begin
            @(posedge CLK);
        end while (ack !== 1'b1);
        check("ack", 32'h1, {31'h0, ack});
        rdata = dout;
        bus[46:45] <= 2'b00;
    endtask : wb
    task automatic fire(input logic [3:0] p);
        @(posedge CLK);
        gp <= {1'b1, p};
        @(posedge CLK);
        gp <= 5'h0;
    endtask : fire
    // Set a flag, read it, clear it with a one, read again
    task automatic flag(input logic [3:0] p, input int b, input logic [31:0] base);
        fire(p);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("flag set", base | (32'h1 << b), rdata);
        wb(1'b1, ST, 4'hc, 32'h1 << b);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("flag cleared", base, rdata);
    endtask : flag
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        wb(1'b0, ST, 4'hf, 32'h0);
        check("reset status", FWD, rdata);
        wb(1'b0, 8'h50, 4'hf, 32'h0);
        check("unmapped", 32'h0, rdata);
        intx <= 1'b1;
        wb(1'b0, ST, 4'hf, 32'h0);
        check("pending", FWD | 32'h0008_0000, rdata);
        intx <= 1'b0;
        fire(4'h0);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("gated parity", FWD, rdata);
        wb(1'b1, CT, 4'hf, 32'h0);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("no fast b2b", FWD & ~32'h0080_0000, rdata);
        wb(1'b1, CT, 4'hf, 32'h5);
        flag(4'h0, 24, FWD);
        flag(4'h8, 27, FWD);
        flag(4'h9, 28, FWD);
        flag(4'ha, 29, FWD);
        flag(4'hb, 30, FWD);
        flag(4'hc, 31, FWD);
        hold <= 1'b1;
        repeat (4) @(posedge CLK);
        hold <= 1'b0;
        wb(1'b1, ST, 4'hc, 32'h0);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("pin parity", FWD | 32'h0100_0000, rdata);
        wb(1'b1, ST, 4'h8, 32'h0100_0000);
        wb(1'b0, ST, 4'hf, 32'h0);
        check("pin parity cleared", FWD, rdata);
        wb(1'b1, CT, 4'hf, 32'h2);
        flag(4'h3, 31, REV);
        wb(1'b1, CT, 4'hf, 32'h3);
        flag(4'h1, 24, REV);
        flag(4'h2, 24, REV);
        flag(4'h4, 27, REV);
        flag(4'h5, 28, REV);
        flag(4'h6, 29, REV);
        flag(4'h7, 30, REV);
        final_report();
    end
endmodule : tb
